// ===== hdl/psuc_pkg.sv
package psuc_pkg;
	localparam int PSUC_AW = 8;
	localparam int PSUC_DW = 32;
	localparam logic [7:0] PSUC_OFS_GEN_CTRL = 8'h00;
	localparam logic [7:0] PSUC_OFS_MASTER_CTRL = 8'h04;
	localparam logic [7:0] PSUC_OFS_RISE_SET = 8'h08;
	localparam logic [7:0] PSUC_OFS_DBCTL_SET = 8'h0C;
	localparam logic [7:0] PSUC_OFS_OUTB_SET = 8'h10;
	localparam logic [7:0] PSUC_OFS_RISE_ACT = 8'h14;
	localparam logic [7:0] PSUC_OFS_DBCTL_ACT = 8'h18;
	localparam logic [7:0] PSUC_OFS_OUTB_ACT = 8'h1C;
	localparam int PSUC_RISE_UPD_POS = 12;
	localparam int PSUC_DBCTL_UPD_POS = 10;
	localparam int PSUC_OUTB_UPD_POS = 8;
	localparam int PSUC_SYNC_REQ_POS = 0;
	localparam logic [15:0] PSUC_CTRL_MASK = 16'h3F00;
	localparam logic [31:0] PSUC_RST_VAL = 32'h00000000;
	localparam logic [31:0] PSUC_BAD_ADDR_VAL = 32'h00000000;
	typedef enum logic [1:0] {
		PSUC_UPD_IMMEDIATE = 2'h0,
		PSUC_UPD_RESERVED = 2'h1,
		PSUC_UPD_LOCAL = 2'h2,
		PSUC_UPD_GLOBAL = 2'h3
	} psuc_upd_mode_t;
endpackage : psuc_pkg

// ===== hdl/psuc_top.sv
// Functional notes
// - Bits 13:12 choose rise delay update mode.
// - Bits 11:10 dead-band ctrl, 9:8 output-B mode.
// - Mode 0: write applies immediately.
// - Mode 2: apply at next counter zero.
// - Mode 3: apply at zero after sync request.
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
module psuc_top #(
	parameter int SET_W = 32
) (
	input wire logic mclk_in, // System clock.
	input wire logic rst_n_in, // Async reset, active low.
	input wire logic wb_cyc_in, // Wishbone cycle.
	input wire logic wb_stb_in, // Wishbone strobe.
	input wire logic wb_we_in, // Wishbone write enable.
	input wire logic [psuc_pkg::PSUC_AW-1:0] wb_adr_in, // Byte address.
	input wire logic [3:0] wb_sel_in, // Byte enables.
	input wire logic [psuc_pkg::PSUC_DW-1:0] wb_dat_in, // Write data.
	output logic [psuc_pkg::PSUC_DW-1:0] wb_dat_out, // Read data.
	output logic wb_ack_out, // Wishbone acknowledge.
	input wire logic cnt_zero_in, // Counter at zero, same clock.
	output logic [SET_W-1:0] rise_delay_out, // Active rise delay.
	output logic [SET_W-1:0] deadband_ctrl_out, // Active dead-band control.
	output logic [SET_W-1:0] out_b_action_out // Active output-B action.
);
	import psuc_pkg::*;

	if (SET_W < 1 || SET_W > PSUC_DW) begin : g_bad_width
		$error("SET_W out of range");
	end

	logic [15:0] ctrl_r;
	logic sync_req_r;
	logic [SET_W-1:0] shadow_r [3];
	logic [SET_W-1:0] active_r [3];
	logic [2:0] pend_r;
	logic [2:0] wr_set;
	logic [1:0] mode [3];
	logic req;
	logic wr;
	logic [31:0] wmask;
	logic [31:0] ctrl_wr;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign wr = req && wb_we_in;
	assign wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
	assign ctrl_wr = merge({16'h0000, ctrl_r}, wb_dat_in, wmask);
	assign mode[0] = ctrl_r[PSUC_RISE_UPD_POS +: 2];
	assign mode[1] = ctrl_r[PSUC_DBCTL_UPD_POS +: 2];
	assign mode[2] = ctrl_r[PSUC_OUTB_UPD_POS +: 2];
	assign wr_set[0] = wr && wb_adr_in == PSUC_OFS_RISE_SET;
	assign wr_set[1] = wr && wb_adr_in == PSUC_OFS_DBCTL_SET;
	assign wr_set[2] = wr && wb_adr_in == PSUC_OFS_OUTB_SET;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wb_ack_out <= 1'b0;
		end else begin
			wb_ack_out <= req;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_r <= 16'h0000;
		end else if (wr && wb_adr_in == PSUC_OFS_GEN_CTRL) begin
			ctrl_r <= ctrl_wr[15:0] & PSUC_CTRL_MASK;
		end
	end

	// Sync request: a new request wins over the clear at counter zero.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync_req_r <= 1'b0;
		end else if (wr && wb_adr_in == PSUC_OFS_MASTER_CTRL && wb_sel_in[0] &&
			wb_dat_in[PSUC_SYNC_REQ_POS]) begin
			sync_req_r <= 1'b1;
		end else if (cnt_zero_in) begin
			sync_req_r <= 1'b0;
		end
	end

	for (genvar g = 0; g < 3; g++) begin : g_set
		logic [31:0] sh_wr;
		logic apply;
		assign sh_wr = merge(32'(shadow_r[g]), wb_dat_in, wmask);
		// Reserved mode 1 is treated like mode 2.
		// A setting write in the same cycle as counter zero wins and, outside mode 0, stays pending.
		assign apply = pend_r[g] && cnt_zero_in &&
			(mode[g] != PSUC_UPD_GLOBAL || sync_req_r);

		always_ff @(posedge mclk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				shadow_r[g] <= '0;
				pend_r[g] <= 1'b0;
			end else if (wr_set[g]) begin
				shadow_r[g] <= sh_wr[SET_W-1:0];
				pend_r[g] <= mode[g] != PSUC_UPD_IMMEDIATE;
			end else if (apply) begin
				pend_r[g] <= 1'b0;
			end
		end

		always_ff @(posedge mclk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				active_r[g] <= '0;
			end else if (wr_set[g] && mode[g] == PSUC_UPD_IMMEDIATE) begin
				active_r[g] <= sh_wr[SET_W-1:0];
			end else if (apply) begin
				active_r[g] <= shadow_r[g];
			end
		end
	end

	assign rise_delay_out = active_r[0];
	assign deadband_ctrl_out = active_r[1];
	assign out_b_action_out = active_r[2];

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wb_dat_out <= PSUC_RST_VAL;
		end else if (req && !wb_we_in) begin
			case (wb_adr_in)
				PSUC_OFS_GEN_CTRL: wb_dat_out <= {16'h0000, ctrl_r};
				PSUC_OFS_MASTER_CTRL: wb_dat_out <= {31'h00000000, sync_req_r};
				PSUC_OFS_RISE_SET: wb_dat_out <= 32'(shadow_r[0]);
				PSUC_OFS_DBCTL_SET: wb_dat_out <= 32'(shadow_r[1]);
				PSUC_OFS_OUTB_SET: wb_dat_out <= 32'(shadow_r[2]);
				PSUC_OFS_RISE_ACT: wb_dat_out <= 32'(active_r[0]);
				PSUC_OFS_DBCTL_ACT: wb_dat_out <= 32'(active_r[1]);
				PSUC_OFS_OUTB_ACT: wb_dat_out <= 32'(active_r[2]);
				default: wb_dat_out <= PSUC_BAD_ADDR_VAL;
			endcase
		end
	end

	property p_immediate;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(wr_set[0] && mode[0] == PSUC_UPD_IMMEDIATE && wb_sel_in == 4'hF)
			|=> rise_delay_out == $past(wb_dat_in[SET_W-1:0]);
	endproperty
	a_immediate: assert property (p_immediate) else $error("immediate write not applied");

	property p_local_hold;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(wr_set[1] && mode[1] == PSUC_UPD_LOCAL && !cnt_zero_in)
			|=> $stable(deadband_ctrl_out);
	endproperty
	a_local_hold: assert property (p_local_hold) else $error("local write applied early");

	property p_local_apply;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(pend_r[2] && mode[2] == PSUC_UPD_LOCAL && cnt_zero_in && !wr_set[2])
			|=> out_b_action_out == $past(shadow_r[2]) && !pend_r[2];
	endproperty
	a_local_apply: assert property (p_local_apply) else $error("local update missed zero");

	property p_global_wait;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(pend_r[0] && mode[0] == PSUC_UPD_GLOBAL && !sync_req_r && !wr_set[0])
			|=> $stable(rise_delay_out);
	endproperty
	a_global_wait: assert property (p_global_wait) else $error("global applied w/o request");

	property p_global_apply;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(pend_r[1] && mode[1] == PSUC_UPD_GLOBAL && sync_req_r && cnt_zero_in && !wr_set[1])
			|=> deadband_ctrl_out == $past(shadow_r[1]);
	endproperty
	a_global_apply: assert property (p_global_apply) else $error("global update missed");

	property p_sync_clear;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(sync_req_r && cnt_zero_in && !wr) |=> !sync_req_r;
	endproperty
	a_sync_clear: assert property (p_sync_clear) else $error("sync request not cleared");

	property p_field_pos;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(wr && wb_adr_in == PSUC_OFS_GEN_CTRL && wb_sel_in[1])
			|=> ctrl_r[13:8] == $past(wb_dat_in[13:8]);
	endproperty
	a_field_pos: assert property (p_field_pos) else $error("mode field not stored");

	property p_ack;
		@(posedge mclk_in) disable iff (!rst_n_in)
		req |=> wb_ack_out ##1 !wb_ack_out;
	endproperty
	a_ack: assert property (p_ack) else $error("ack timing wrong");

	property p_rsvd_zero;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(req && !wb_we_in && wb_adr_in == PSUC_OFS_GEN_CTRL)
			|=> (wb_dat_out & ~{16'h0000, PSUC_CTRL_MASK}) == 32'h00000000;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved control bits set");

	property p_sync_set;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(wr && wb_adr_in == PSUC_OFS_MASTER_CTRL && wb_sel_in[0] &&
			wb_dat_in[PSUC_SYNC_REQ_POS]) |=> sync_req_r;
	endproperty
	a_sync_set: assert property (p_sync_set) else $error("sync request not taken");

	property p_imm_pend;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(wr_set[2] && mode[2] == PSUC_UPD_IMMEDIATE)
			|=> !pend_r[2];
	endproperty
	a_imm_pend: assert property (p_imm_pend) else $error("immediate write left pending");

	property p_global_hold;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(pend_r[2] && mode[2] == PSUC_UPD_GLOBAL && !sync_req_r && cnt_zero_in && !wr_set[2])
			|=> pend_r[2] && $stable(out_b_action_out);
	endproperty
	a_global_hold: assert property (p_global_hold) else $error("global applied at bare zero");
endmodule : psuc_top

// ===== dv/testbench.sv
`timescale 1ns/100ps
`define CHK(g, w) begin n_compared++; if ((g) !== (w)) begin err_total++; \
	$display("unexpected at %0t: read %h expected %h", $time, g, w); end end
module testbench;
	import psuc_pkg::*;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic wb_cyc_in = 1'b0;
	logic wb_stb_in = 1'b0;
	logic wb_we_in = 1'b0;
	logic cnt_zero_in = 1'b0;
	logic [7:0] wb_adr_in = 8'h00;
	logic [3:0] wb_sel_in = 4'h0;
	logic [31:0] wb_dat_in = 32'h00000000;
	logic [31:0] wb_dat_out, rise_delay_out, deadband_ctrl_out, out_b_action_out;
	logic wb_ack_out;
	logic [31:0] exp_q[$];
	logic [31:0] exp_v;
	logic [31:0] act[3];
	logic [31:0] outs[3];
	psuc_upd_mode_t md[3] = '{PSUC_UPD_IMMEDIATE, PSUC_UPD_LOCAL, PSUC_UPD_GLOBAL};
	int err_total = 0;
	int n_compared = 0;
	int seed = 11204;
	psuc_top psuc_top_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
		.wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
		.wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
		.wb_ack_out(wb_ack_out), .cnt_zero_in(cnt_zero_in), .rise_delay_out(rise_delay_out),
		.deadband_ctrl_out(deadband_ctrl_out), .out_b_action_out(out_b_action_out));
	initial forever #10 mclk_in = ~mclk_in;
	assign outs[0] = rise_delay_out;
	assign outs[1] = deadband_ctrl_out;
	assign outs[2] = out_b_action_out;
	task print_verdict;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict
	// Request is held until ack is sampled high at a rising edge, then released.
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= w;
		wb_adr_in <= a;
		wb_dat_in <= d;
		wb_sel_in <= 4'hF;
		n = 0;
		do begin
			@(posedge mclk_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 50);
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		wb_we_in <= 1'b0;
		if (wb_ack_out !== 1'b1) begin
			err_total++;
			$display("unexpected at %0t: no ack", $time);
			print_verdict();
		end
	endtask : xfer
	task rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		xfer(1'b0, a, 32'h00000000);
	endtask : rd
	task zero;
		@(posedge mclk_in);
		cnt_zero_in <= 1'b1;
		@(posedge mclk_in);
		cnt_zero_in <= 1'b0;
	endtask : zero
	// Read data is taken at the rising edge at which ack is sampled high.
	always @(posedge mclk_in) begin
		if (wb_ack_out === 1'b1 && wb_cyc_in === 1'b1 && wb_we_in === 1'b0) begin
			if (exp_q.size() == 0) begin
				`CHK(1'b1, 1'b0)
			end else begin
				exp_v = exp_q.pop_front();
				`CHK(wb_dat_out, exp_v)
			end
		end
	end
	initial begin
		logic [31:0] d;
		logic [31:0] c;
		repeat (20) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		rd(PSUC_OFS_GEN_CTRL, PSUC_RST_VAL);
		xfer(1'b1, PSUC_OFS_GEN_CTRL, 32'hFFFFFFFF);
		rd(PSUC_OFS_GEN_CTRL, {16'h0000, PSUC_CTRL_MASK});
		rd(8'hFC, PSUC_BAD_ADDR_VAL);
		act = '{default: 32'h00000000};
		for (int i = 0; i < 3; i++) begin
			for (int f = 0; f < 3; f++) begin
				c = 32'(md[i]) << (PSUC_RISE_UPD_POS - 2 * f);
				xfer(1'b1, PSUC_OFS_GEN_CTRL, c);
				rd(PSUC_OFS_GEN_CTRL, c);
				d = $random(seed);
				xfer(1'b1, PSUC_OFS_RISE_SET + 8'(4 * f), d);
				rd(PSUC_OFS_RISE_SET + 8'(4 * f), d);
				if (md[i] == PSUC_UPD_IMMEDIATE) act[f] = d;
				rd(PSUC_OFS_RISE_ACT + 8'(4 * f), act[f]);
				for (int k = 0; k < 3; k++) `CHK(outs[k], act[k])
				if (md[i] != PSUC_UPD_IMMEDIATE) begin
					zero();
					if (md[i] == PSUC_UPD_GLOBAL) begin
						rd(PSUC_OFS_RISE_ACT + 8'(4 * f), act[f]);
						for (int k = 0; k < 3; k++) `CHK(outs[k], act[k])
						xfer(1'b1, PSUC_OFS_MASTER_CTRL, 32'h00000001);
						rd(PSUC_OFS_MASTER_CTRL, 32'h00000001);
						zero();
						rd(PSUC_OFS_MASTER_CTRL, 32'h00000000);
					end
					act[f] = d;
					rd(PSUC_OFS_RISE_ACT + 8'(4 * f), act[f]);
					for (int k = 0; k < 3; k++) `CHK(outs[k], act[k])
				end
			end
			$display("update mode %0d test done", md[i]);
		end
		rst_n_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		for (int k = 0; k < 3; k++) `CHK(outs[k], PSUC_RST_VAL)
		rst_n_in <= 1'b1;
		rd(PSUC_OFS_GEN_CTRL, PSUC_RST_VAL);
		rd(PSUC_OFS_MASTER_CTRL, PSUC_RST_VAL);
		$display("mid-run reset test done");
		print_verdict();
	end
endmodule : testbench
